/* digital_io_defines.svh */
`ifndef DIGITAL_IO_DEFINES_SVH
`define DIGITAL_IO_DEFINES_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define DIO_WAVE_W      8
`define DIO_PFL_N       16
`define DIO_TRIG_N      8
`define DIO_FIFO_DEPTH  2047
`define DIO_FIFO_AW     11
`define DIO_FIFO_HALF   11'h400

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DIO_CLK_MHZ     200
`define DIO_FILT_SHORT_NS 125
`define DIO_FILT_MID_NS   6425
`define DIO_FILT_LONG_NS  2560000
`define DIO_NS_TO_CYC(ns) (((ns) * `DIO_CLK_MHZ + 999) / 1000)
`define DIO_FILT_CNT_W  19

// ----------------------------------------------------------------
// sample clock select codes
// ----------------------------------------------------------------
`define DIO_SCLK_TRIG0     5'h10
`define DIO_SCLK_AI_SAMPLE 5'h18
`define DIO_SCLK_AI_CONV   5'h19
`define DIO_SCLK_AO_SAMPLE 5'h1a
`define DIO_SCLK_CTR0      5'h1b
`define DIO_SCLK_CTR1      5'h1c

`endif

/* digital_io_pkg.sv */
`include "digital_io_defines.svh"
package digital_io_pkg;

  // ----------------------------------------------------------------
  // modes and settings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PFL_STATIC_IN  = 2'h0,
    PFL_STATIC_OUT = 2'h1,
    PFL_TIMING_IN  = 2'h2,
    PFL_TIMING_OUT = 2'h3
  } pfl_mode_e;

  typedef enum logic [1:0] {
    FILT_OFF   = 2'h0,
    FILT_SHORT = 2'h1,
    FILT_MID   = 2'h2,
    FILT_LONG  = 2'h3
  } filt_e;

  typedef enum logic [1:0] {
    XFER_PROG = 2'h0,
    XFER_IRQ  = 2'h1,
    XFER_DMA  = 2'h2
  } xfer_e;

  typedef enum logic [2:0] {
    OUT_IDLE = 3'b001,
    OUT_RUN  = 3'b010,
    OUT_HALT = 3'b100
  } out_state_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    pfl_mode_e   mode;
    filt_e       filt;
    logic [2:0]  tsrc;  // 0 ai sample .. 4 ctr1, 5 wave in, 6 wave out
  } pfl_cfg_s;

  typedef struct packed {
    logic        ai_sample;
    logic        ai_convert;
    logic        ao_sample;
    logic [1:0]  ctr;
  } subsys_clk_s;

  typedef struct packed {
    logic        out_en;
    logic        out_regen;
    logic [4:0]  out_clk_sel;
    logic        in_en;
    logic [4:0]  in_clk_sel;
    xfer_e       out_xfer;
    xfer_e       in_xfer;
  } wave_cfg_s;

endpackage : digital_io_pkg

/* digital_io_waveform_port.sv */
`timescale 1ns/1ps
`include "digital_io_defines.svh"
module digital_io_waveform_port
  import digital_io_pkg::*;
#(
  parameter int FILT_LONG_CYC = `DIO_NS_TO_CYC(`DIO_FILT_LONG_NS)  // long debounce count
)(
  input  wire logic                     core_clk,       // 200 MHz clock
  input  wire logic                     rst_n,          // async reset, low
  input  wire logic [7:0]               p0_in,          // waveform port lines, input
  output logic      [7:0]               p0_out,         // waveform port lines, output
  output logic      [7:0]               p0_oe,          // waveform port lines, drive enable
  input  wire logic [15:0]              pfl_in,         // function lines, input
  output logic      [15:0]              pfl_out,        // function lines, output
  output logic      [15:0]              pfl_oe,         // function lines, drive enable
  input  wire logic [7:0]               trig_bus_in,    // trigger bus lines
  input  wire subsys_clk_s              subsys_clk,     // other subsystem clocks
  input  wire logic [7:0]               p0_dir,         // 1 = line is output
  input  wire logic [7:0]               p0_static_out,  // static output values
  input  wire pfl_cfg_s [15:0]          pfl_cfg,        // per function line setup
  input  wire logic [15:0]              pfl_static_out, // static function line values
  input  wire wave_cfg_s                wave_cfg,       // waveform setup
  input  wire logic                     host_wr_valid,  // host offers output sample
  input  wire logic [7:0]               host_wr_data,   // output sample
  output logic                          host_wr_ready,  // output FIFO takes sample
  output logic                          host_rd_valid,  // captured sample available
  output logic      [7:0]               host_rd_data,   // captured sample
  input  wire logic                     host_rd_ready,  // host takes sample
  output logic                          out_xfer_req,   // output FIFO wants data
  output logic                          in_xfer_req,    // input FIFO wants draining
  output logic      [10:0]              out_fill,       // output FIFO level
  output logic      [10:0]              in_fill,        // input FIFO level
  output logic      [7:0]               p0_state,       // sampled port lines
  output logic      [15:0]              pfl_state,      // debounced function lines
  output logic                          out_running,    // generation active
  output logic                          out_underrun,   // sticky lost output sample
  output logic                          in_overflow,    // sticky lost input sample
  input  wire logic                     underrun_clr,   // clear underrun flag
  input  wire logic                     overflow_clr    // clear overflow flag
);

  localparam int SHORT_CYC = `DIO_NS_TO_CYC(`DIO_FILT_SHORT_NS);
  localparam int MID_CYC   = `DIO_NS_TO_CYC(`DIO_FILT_MID_NS);
  localparam logic [`DIO_FILT_CNT_W-1:0] SHORT_LIM = `DIO_FILT_CNT_W'(SHORT_CYC);
  localparam logic [`DIO_FILT_CNT_W-1:0] MID_LIM   = `DIO_FILT_CNT_W'(MID_CYC);
  localparam logic [`DIO_FILT_CNT_W-1:0] LONG_LIM  = `DIO_FILT_CNT_W'(FILT_LONG_CYC);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pick a sample clock level from its select code
  function automatic logic clk_pick(input logic [4:0] sel, input logic [15:0] pfl,
                                    input logic [7:0] trig, input subsys_clk_s sc);
    logic r;
    r = 1'b0;
    if (sel < `DIO_SCLK_TRIG0) begin
      r = pfl[sel[3:0]];
    end else if (sel < `DIO_SCLK_AI_SAMPLE) begin
      r = trig[sel[2:0]];
    end else begin
      case (sel)
        `DIO_SCLK_AI_SAMPLE: r = sc.ai_sample;
        `DIO_SCLK_AI_CONV:   r = sc.ai_convert;
        `DIO_SCLK_AO_SAMPLE: r = sc.ao_sample;
        `DIO_SCLK_CTR0:      r = sc.ctr[0];
        `DIO_SCLK_CTR1:      r = sc.ctr[1];
        default:             r = 1'b0;
      endcase
    end
    return r;
  endfunction : clk_pick

  // transfer request for a given method
  function automatic logic xfer_want(input xfer_e m, input logic dma_ok, input logic irq_ok);
    logic r;
    r = 1'b0;
    case (m)
      XFER_DMA: r = dma_ok;
      XFER_IRQ: r = irq_ok;
      default:  r = 1'b0;
    endcase
    return r;
  endfunction : xfer_want

  // ----------------------------------------------------------------
  // function lines: debounce and drive
  // ----------------------------------------------------------------
  logic [7:0] tsrc_vec;
  logic       out_lvl_q;
  logic       in_lvl_q;

  assign tsrc_vec = {1'b0, out_lvl_q, in_lvl_q, subsys_clk.ctr[1], subsys_clk.ctr[0],
                     subsys_clk.ao_sample, subsys_clk.ai_convert, subsys_clk.ai_sample};

  genvar gi;
  generate
    for (gi = 0; gi < `DIO_PFL_N; gi++) begin : g_pfl
      logic [`DIO_FILT_CNT_W-1:0] cnt_q;
      logic [`DIO_FILT_CNT_W-1:0] lim;
      logic                       oe_mode;

      always_comb begin
        case (pfl_cfg[gi].filt)
          FILT_SHORT: lim = SHORT_LIM;
          FILT_MID:   lim = MID_LIM;
          FILT_LONG:  lim = LONG_LIM;
          default:    lim = '0;
        endcase
      end

      // new level accepted only after holding lim cycles, both edges alike
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_q         <= '0;
          pfl_state[gi] <= 1'b0;
        end else if (pfl_in[gi] == pfl_state[gi]) begin
          cnt_q <= '0;
        end else if (pfl_cfg[gi].filt == FILT_OFF || cnt_q + 1'b1 >= lim) begin
          cnt_q         <= '0;
          pfl_state[gi] <= pfl_in[gi];
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end

      assign oe_mode = (pfl_cfg[gi].mode == PFL_STATIC_OUT) || (pfl_cfg[gi].mode == PFL_TIMING_OUT);

      // static or timing output per line
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          pfl_out[gi] <= 1'b0;
          pfl_oe[gi]  <= 1'b0;
        end else begin
          pfl_oe[gi]  <= oe_mode;
          pfl_out[gi] <= (pfl_cfg[gi].mode == PFL_TIMING_OUT) ? tsrc_vec[pfl_cfg[gi].tsrc]
                                                               : pfl_static_out[gi];
        end
      end

      a_timing_out: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pfl_cfg[gi].mode == PFL_TIMING_OUT) |=> pfl_out[gi] == $past(tsrc_vec[pfl_cfg[gi].tsrc]) && pfl_oe[gi])
        else $error("timing output wrong");

      a_filter_short: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pfl_cfg[gi].filt == FILT_SHORT && $changed(pfl_state[gi])) |-> $past(pfl_in[gi] != pfl_state[gi], 24))
        else $error("short filter too quick");
    end
  endgenerate

  // ----------------------------------------------------------------
  // sample clock select and edge detect
  // ----------------------------------------------------------------
  logic out_prev_q;
  logic in_prev_q;
  logic out_edge;
  logic in_edge;

  // clocks are borrowed, never made here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_lvl_q  <= 1'b0;
      in_lvl_q   <= 1'b0;
      out_prev_q <= 1'b0;
      in_prev_q  <= 1'b0;
    end else begin
      out_lvl_q  <= clk_pick(wave_cfg.out_clk_sel, pfl_state, trig_bus_in, subsys_clk);
      in_lvl_q   <= clk_pick(wave_cfg.in_clk_sel, pfl_state, trig_bus_in, subsys_clk);
      out_prev_q <= out_lvl_q;
      in_prev_q  <= in_lvl_q;
    end
  end

  assign out_edge = out_lvl_q & ~out_prev_q;
  assign in_edge  = in_lvl_q & ~in_prev_q;

  // ----------------------------------------------------------------
  // waveform output path
  // ----------------------------------------------------------------
  out_state_e      out_state_q;
  logic [7:0]      wave_q;
  logic [7:0]      out_head;
  logic            out_full;
  logic            out_empty;
  logic            out_fire;
  logic            recirc;
  logic            out_push;
  logic            underrun_set;

  assign out_running  = (out_state_q == OUT_RUN);
  assign out_fire     = out_running & out_edge & ~out_empty;
  assign recirc       = out_fire & wave_cfg.out_regen;
  assign host_wr_ready = ~out_full & ~recirc;
  assign out_push     = recirc | (host_wr_valid & host_wr_ready);
  assign underrun_set = out_running & out_edge & out_empty;

  sample_fifo u_out_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .push     (out_push),
    .wr_data  (recirc ? out_head : host_wr_data),
    .pop      (out_fire),
    .rd_data  (out_head),
    .fill     (out_fill),
    .full     (out_full),
    .empty    (out_empty)
  );

  // generation sequence; streaming halts on underrun, regeneration keeps going
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_state_q <= OUT_IDLE;
    end else begin
      case (out_state_q)
        OUT_IDLE: if (wave_cfg.out_en) out_state_q <= OUT_RUN;
        OUT_RUN: begin
          if (!wave_cfg.out_en) begin
            out_state_q <= OUT_IDLE;
          end else if (underrun_set && !wave_cfg.out_regen) begin
            out_state_q <= OUT_HALT;
          end
        end
        OUT_HALT: if (!wave_cfg.out_en) out_state_q <= OUT_IDLE;
        default:  out_state_q <= OUT_IDLE;
      endcase
    end
  end

  // current output sample
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_q <= '0;
    end else if (out_fire) begin
      wave_q <= out_head;
    end
  end

  // first port drive: waveform while enabled, static otherwise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_out   <= '0;
      p0_oe    <= '0;
      p0_state <= '0;
    end else begin
      p0_oe    <= p0_dir;
      p0_out   <= wave_cfg.out_en ? wave_q : p0_static_out;
      p0_state <= p0_in;
    end
  end

  // ----------------------------------------------------------------
  // waveform input path
  // ----------------------------------------------------------------
  logic in_full;
  logic in_empty;
  logic in_push;
  logic overflow_set;

  assign in_push       = wave_cfg.in_en & in_edge & ~in_full;
  assign overflow_set  = wave_cfg.in_en & in_edge & in_full;
  assign host_rd_valid = ~in_empty;

  sample_fifo u_in_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .push     (in_push),
    .wr_data  (p0_in),
    .pop      (host_rd_valid & host_rd_ready),
    .rd_data  (host_rd_data),
    .fill     (in_fill),
    .full     (in_full),
    .empty    (in_empty)
  );

  // ----------------------------------------------------------------
  // lost-sample flags and transfer requests
  // ----------------------------------------------------------------
  // set wins over clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_underrun <= 1'b0;
      in_overflow  <= 1'b0;
    end else begin
      out_underrun <= underrun_set | (out_underrun & ~underrun_clr);
      in_overflow  <= overflow_set | (in_overflow & ~overflow_clr);
    end
  end

  // requests for dma or interrupt service, none for programmed access
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_xfer_req <= 1'b0;
      in_xfer_req  <= 1'b0;
    end else begin
      out_xfer_req <= ~wave_cfg.out_regen &
                      xfer_want(wave_cfg.out_xfer, ~out_full, out_fill < `DIO_FIFO_HALF);
      in_xfer_req  <= xfer_want(wave_cfg.in_xfer, ~in_empty, in_fill >= `DIO_FIFO_HALF);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_underrun_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    underrun_set |=> out_underrun) else $error("underrun not flagged");

  a_overflow_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    (overflow_set && overflow_clr) |=> in_overflow) else $error("overflow lost to clear");

  a_regen_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    (recirc && !(host_wr_valid && host_wr_ready)) |=> $stable(out_fill)) else $error("regen changed level");

  a_stream_pops: assert property (@(posedge core_clk) disable iff (!rst_n)
    (out_fire && !wave_cfg.out_regen && !host_wr_valid) |=> out_fill == $past(out_fill) - 11'h1)
    else $error("stream did not pop");

  a_capture_push: assert property (@(posedge core_clk) disable iff (!rst_n)
    (in_push && !host_rd_ready) |=> (in_fill == $past(in_fill) + 11'h1) && !in_empty)
    else $error("capture not stored");

  a_stream_halt: assert property (@(posedge core_clk) disable iff (!rst_n)
    (underrun_set && !wave_cfg.out_regen && wave_cfg.out_en) |=> out_state_q == OUT_HALT [*1] ##1 !out_fire)
    else $error("stream kept running");

  a_sample_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
    (out_fire && wave_cfg.out_en) ##1 wave_cfg.out_en |=> p0_out == $past(out_head, 2))
    else $error("sample not driven");

  a_p0_dir_oe: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 p0_oe == $past(p0_dir)) else $error("direction not applied");

  a_sclk_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wave_cfg.in_clk_sel == `DIO_SCLK_AI_SAMPLE) |=> in_lvl_q == $past(subsys_clk.ai_sample))
    else $error("sample clock source not followed");

endmodule : digital_io_waveform_port

/* digital_io_waveform_port_tb_top.sv */
`timescale 1ns/1ps
module digital_io_waveform_port_tb_top import digital_io_pkg::*;;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic            core_clk = 1'b0, rst_n, run, sclk, host_wr_valid, host_wr_ready, host_rd_valid, host_rd_ready;
  logic            out_xfer_req, in_xfer_req, out_running, out_underrun, in_overflow, underrun_clr, overflow_clr;
  logic [7:0]      p0_in, p0_out, p0_oe, p0_dir, p0_static_out, host_wr_data, host_rd_data, p0_state, trig_bus_in;
  logic [15:0]     pfl_in, pfl_out, pfl_oe, pfl_static_out, pfl_state;
  logic [10:0]     out_fill, in_fill;
  pfl_cfg_s [15:0] pfl_cfg;
  wave_cfg_s       wave_cfg;
  subsys_clk_s     subsys_clk;
  int              n_fail = 0, n_checks = 0, cyc = 0;
  logic [7:0]      wdat [3];
  // borrowed clock feeds trigger line 0 and the analog input sample clock
  assign trig_bus_in = {7'h00, sclk};
  assign subsys_clk = {sclk, 4'h0};
  always #2.5 core_clk = ~core_clk;
  sample_clock_model src_u (.core_clk(core_clk), .en(run), .sclk(sclk), .pattern(p0_in));
  digital_io_waveform_port #(.FILT_LONG_CYC(40)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .pfl_in(pfl_in),
    .pfl_out(pfl_out), .pfl_oe(pfl_oe), .trig_bus_in(trig_bus_in), .subsys_clk(subsys_clk), .p0_dir(p0_dir),
    .p0_static_out(p0_static_out), .pfl_cfg(pfl_cfg), .pfl_static_out(pfl_static_out), .wave_cfg(wave_cfg),
    .host_wr_valid(host_wr_valid), .host_wr_data(host_wr_data), .host_wr_ready(host_wr_ready),
    .host_rd_valid(host_rd_valid), .host_rd_data(host_rd_data), .host_rd_ready(host_rd_ready),
    .out_xfer_req(out_xfer_req), .in_xfer_req(in_xfer_req), .out_fill(out_fill), .in_fill(in_fill),
    .p0_state(p0_state), .pfl_state(pfl_state), .out_running(out_running), .out_underrun(out_underrun),
    .in_overflow(in_overflow), .underrun_clr(underrun_clr), .overflow_clr(overflow_clr));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run;
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  // valid held across all three words, each kept until ready is seen
  task automatic wr_burst;
    int w;
    host_wr_valid = 1'b1;
    for (int i = 0; i < 3; i++) begin
      host_wr_data = wdat[i];
      w = 0;
      @(posedge core_clk);
      while (host_wr_ready !== 1'b1 && w < 50) begin
        w++;
        @(posedge core_clk);
      end
      check(host_wr_ready, 1'b1);
      #1;
    end
    host_wr_valid = 1'b0;
  endtask : wr_burst
  // ready held for n pops, data compared at each taking edge
  task automatic rd_burst(input logic [7:0] first, input int n);
    host_rd_ready = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      check(host_rd_valid, 1'b1);
      check(host_rd_data, first + i[7:0]);
      #1;
    end
    host_rd_ready = 1'b0;
  endtask : rd_burst
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 45000) begin
      n_fail++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    run = 1'b0;
    {p0_dir, p0_static_out, pfl_in, pfl_static_out, host_wr_data} = '0;
    {host_wr_valid, host_rd_ready, underrun_clr, overflow_clr} = 4'h0;
    wave_cfg = '0;
    for (int i = 0; i < 16; i++) pfl_cfg[i] = '{PFL_STATIC_IN, FILT_OFF, 3'h7};
    wdat = '{8'h11, 8'h22, 8'h33};
    repeat (4) @(posedge core_clk);
    #1 rst_n = 1'b1;
    // static directions, static values and a timing output line
    p0_dir = 8'h0f;
    p0_static_out = 8'ha5;
    pfl_cfg[0].mode = PFL_STATIC_OUT;
    pfl_cfg[5] = '{PFL_TIMING_OUT, FILT_OFF, 3'h0};
    pfl_cfg[3].filt = FILT_SHORT;
    pfl_cfg[6].filt = FILT_LONG;
    pfl_static_out = 16'h0001;
    step(2);
    check(p0_oe, 8'h0f);
    check(p0_state, 8'h5a);
    check(p0_out, 8'ha5);
    check(pfl_oe, 16'h0021);
    check(pfl_out, 16'h0001);
    // line 3 filtered for 25 cycles, line 6 for 40, line 4 unfiltered
    pfl_in = 16'h0058;
    step(3);
    check(pfl_state, 16'h0010);
    step(17);
    check(pfl_state, 16'h0010);
    step(10);
    check(pfl_state, 16'h0018);
    // regeneration on trigger line 0 while capturing on the analog sample clock
    wr_burst();
    check(out_fill, 11'h003);
    wave_cfg = '{1'b1, 1'b1, 5'h10, 1'b1, 5'h18, XFER_IRQ, XFER_DMA};
    step(2);
    run = 1'b1;
    for (int k = 0; k < 5; k++) begin
      @(posedge sclk);
      step(2);
      check(pfl_out[5], 1'b1);
      step(4);
      check(p0_out, wdat[k % 3]);
    end
    run = 1'b0;
    check(out_fill, 11'h003);
    check(out_xfer_req, 1'b0);
    check(in_fill, 11'h005);
    check(pfl_state, 16'h0058);
    check(in_xfer_req, 1'b1);
    rd_burst(8'h5a, 5);
    step(2);
    check(in_xfer_req, 1'b0);
    // streaming drains the rotated contents, then underruns and halts
    wave_cfg.out_en = 1'b0;
    wave_cfg.out_regen = 1'b0;
    wave_cfg.in_en = 1'b0;
    step(2);
    wave_cfg.out_en = 1'b1;
    step(2);
    run = 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge sclk);
      step(6);
      check(p0_out, wdat[(k == 3) ? 1 : (k + 2) % 3]);
    end
    run = 1'b0;
    check(out_underrun, 1'b1);
    check(out_running, 1'b0);
    check(out_fill, 11'h000);
    underrun_clr = 1'b1;
    step(1);
    underrun_clr = 1'b0;
    step(1);
    check(out_underrun, 1'b0);
    check(out_xfer_req, 1'b1);
    // capture until full with the clear held: the 2048th edge overflows
    wave_cfg.in_en = 1'b1;
    overflow_clr = 1'b1;
    run = 1'b1;
    repeat (2047) @(posedge sclk);
    step(2);
    check(in_fill, 11'h7ff);
    check(in_overflow, 1'b0);
    @(posedge sclk);
    step(2);
    check(in_overflow, 1'b1);
    check(in_fill, 11'h7ff);
    step(1);
    check(in_overflow, 1'b0);
    run = 1'b0;
    overflow_clr = 1'b0;
    complete_run();
  end
endmodule : digital_io_waveform_port_tb_top

/* sample_clock_model.sv */
`timescale 1ns/1ps
module sample_clock_model (
  input  wire logic       core_clk, // bench clock
  input  wire logic       en,       // run the sample clock
  output logic            sclk,     // sample clock level
  output logic      [7:0] pattern   // external data on the first port
);
  logic [4:0] cnt_q; // phase within one period
  // ----------------------------------------------------------------
  // borrowed sample clock, twenty core cycles a period (10 mhz top rate)
  // ----------------------------------------------------------------
  initial cnt_q = 5'h00;
  initial pattern = 8'h5a;
  // phase counter, parked low outside runs so no stray edge appears
  always @(posedge core_clk) begin
    if (!en) cnt_q <= #1 5'h00;
    else if (cnt_q == 5'h13) cnt_q <= #1 5'h00;
    else cnt_q <= #1 cnt_q + 5'h01;
  end
  assign sclk = (cnt_q >= 5'h0a);
  // data steps at period end, stable around each rising edge
  always @(posedge core_clk) begin
    if (cnt_q == 5'h13) pattern <= #1 pattern + 8'h01;
  end
endmodule : sample_clock_model

/* sample_fifo.sv */
`timescale 1ns/1ps
`include "digital_io_defines.svh"
module sample_fifo
  import digital_io_pkg::*;
(
  input  wire logic                     core_clk, // clock
  input  wire logic                     rst_n,    // async reset, low
  input  wire logic                     push,     // write one sample
  input  wire logic [`DIO_WAVE_W-1:0]   wr_data,  // sample written
  input  wire logic                     pop,      // drop head sample
  output logic      [`DIO_WAVE_W-1:0]   rd_data,  // head sample
  output logic      [`DIO_FIFO_AW-1:0]  fill,     // entries held
  output logic                          full,     // no room
  output logic                          empty     // nothing held
);

  localparam logic [`DIO_FIFO_AW-1:0] LAST  = `DIO_FIFO_AW'(`DIO_FIFO_DEPTH - 1);
  localparam logic [`DIO_FIFO_AW-1:0] DEPTH = `DIO_FIFO_AW'(`DIO_FIFO_DEPTH);

  logic [`DIO_WAVE_W-1:0]  mem [`DIO_FIFO_DEPTH];
  logic [`DIO_FIFO_AW-1:0] wr_ptr_q;
  logic [`DIO_FIFO_AW-1:0] rd_ptr_q;
  logic                    do_push;
  logic                    do_pop;

  // push allowed when full only together with a pop
  assign do_pop  = pop & ~empty;
  assign do_push = push & (~full | do_pop);
  assign full    = (fill == DEPTH);
  assign empty   = (fill == '0);
  assign rd_data = mem[rd_ptr_q];

  // storage
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_ptr_q] <= wr_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill     <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        fill <= fill + 1'b1;
      end else if (do_pop && !do_push) begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule : sample_fifo
